/* common/tcd_pkg.sv */
package tcd_pkg;

  // Register addresses on the core's special function register port
  localparam logic [7:0] ADDR_TIMER_CONTROL = 8'h88;
  localparam logic [7:0] ADDR_TIMER_MODE = 8'h89;
  localparam logic [7:0] ADDR_COUNT0_LOW = 8'h8A;
  localparam logic [7:0] ADDR_COUNT1_LOW = 8'h8B;
  localparam logic [7:0] ADDR_COUNT0_HIGH = 8'h8C;
  localparam logic [7:0] ADDR_COUNT1_HIGH = 8'h8D;
  localparam logic [7:0] ADDR_CLOCK_SELECT = 8'h8E;
  localparam logic [7:0] ADDR_CLOCK_SELECT_EXT = 8'hE4;

  // Values after reset
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [3:0] RESET_NIBBLE = 4'h0;

  // Clock select register fields
  localparam int CKS_PRESCALE_LSB = 0;
  localparam int CKS_T0_SYSCLK = 2;
  localparam int CKS_T1_SYSCLK = 3;
  localparam int CKS_AR2_LOW = 4;
  localparam int CKS_AR2_HIGH = 5;
  localparam int CKS_AR3_LOW = 6;
  localparam int CKS_AR3_HIGH = 7;

  // Extended clock select register fields
  localparam int CKX_AR4_LOW = 0;
  localparam int CKX_AR4_HIGH = 1;
  localparam int CKX_AR5_LOW = 2;
  localparam int CKX_AR5_HIGH = 3;
  localparam logic [3:0] CKX_UNUSED_READ = 4'h0;

  // Timer control register fields
  localparam int TCR_RUN0 = 4;
  localparam int TCR_FLAG0 = 5;
  localparam int TCR_RUN1 = 6;
  localparam int TCR_FLAG1 = 7;

  // Timer mode register fields
  localparam int TMR_MODE0_LSB = 0;
  localparam int TMR_CSEL0 = 2;
  localparam int TMR_GATE_ENABLE0 = 3;
  localparam int TMR_MODE1_LSB = 4;
  localparam int TMR_CSEL1 = 6;
  localparam int TMR_GATE_ENABLE1 = 7;

  // Timer operating modes
  localparam logic [1:0] MODE_13BIT = 2'h0;
  localparam logic [1:0] MODE_16BIT = 2'h1;
  localparam logic [1:0] MODE_AUTORELOAD = 2'h2;
  localparam logic [1:0] MODE_SPLIT = 2'h3;

  // Prescaler choices
  localparam logic [1:0] PRESCALE_DIV12 = 2'h0;
  localparam logic [1:0] PRESCALE_DIV4 = 2'h1;
  localparam logic [1:0] PRESCALE_DIV48 = 2'h2;
  localparam logic [1:0] PRESCALE_EXT8 = 2'h3;

  // Prescaler cycle counts
  localparam int PRESCALE_LONGEST = 48;
  localparam logic [5:0] PRESCALE_WRAP = 6'(PRESCALE_LONGEST - 1);
  localparam logic [5:0] PRESCALE_DIV12_MOD = 6'h0C;
  localparam logic [5:0] PRESCALE_DIV4_MOD = 6'h04;
  localparam logic [2:0] EXT_DIV8_WRAP = 3'h7;

endpackage : tcd_pkg

/* dv/tb.sv */
`timescale 1ns/1ps
module tb;
  import tcd_pkg::*;
  logic clk, rst_b, sfrWrEn, sfrRdEn, eventPin0, eventPin1, extIrqIn0, extIrqIn1;
  logic extIn0Polarity, extIn1Polarity, irqEnable0, irqEnable1, irqAck0, irqAck1;
  logic extOscClk, irqReq0, irqReq1, t1Overflow;
  logic [7:0] sfrAddr, sfrWrData, sfrRdData, q;
  logic [3:0] arExtTick, arLowTick, arHighTick;
  int nMismatch = 0;
  int checkCount = 0;
  // Address, byte written, byte read back
  logic [23:0] rows [7] = '{24'h8E5A5A, 24'hE4FF0F, 24'h89A5A5, 24'h8A3C3C, 24'h8DC3C3,
    24'h007700, 24'h880F0F};
  logic [7:0] pre [4] = '{8'h28, 8'h78, 8'h0A, 8'h07};
  tcd_timer01 tcd_timer01_i (.clk, .rst_b, .sfrAddr, .sfrWrData, .sfrWrEn, .sfrRdEn,
    .sfrRdData, .eventPin0, .eventPin1, .extIrqIn0, .extIrqIn1, .extIn0Polarity,
    .extIn1Polarity, .irqEnable0, .irqEnable1, .irqAck0, .irqAck1, .extOscClk, .arExtTick,
    .arLowTick, .arHighTick, .irqReq0, .irqReq1, .t1Overflow);
  tcd_core_model tcd_core_model_i (.clk, .sfrRdData, .sfrAddr, .sfrWrData, .sfrWrEn,
    .sfrRdEn);
  // Free running clock
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // Comparisons
  task automatic chk8(string n, logic [7:0] e, logic [7:0] g);
    checkCount++;
    if (g !== e) begin
      nMismatch++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask : chk8
  task automatic chk1(string n, logic e, logic g);
    checkCount++;
    if (g !== e) begin
      nMismatch++;
      $display("[FAIL] %s expected %b seen %b", n, e, g);
    end
  endtask : chk1
  task automatic w(logic [7:0] a, logic [7:0] d);
    tcd_core_model_i.wr(a, d);
  endtask : w
  task automatic r(logic [7:0] a);
    tcd_core_model_i.rd(a, q);
  endtask : r
  task automatic printVerdict();
    if (nMismatch == 0 && checkCount > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : printVerdict
  // Bounded wait for an output: 0 request 0, 1 request 1, 2 timer 1 overflow
  task automatic waitFor(int sel);
    int k;
    logic v;
    k = 0;
    v = (sel == 0) ? irqReq0 : ((sel == 1) ? irqReq1 : t1Overflow);
    while (v !== 1'b1 && k < 40) begin
      @(negedge clk);
      k++;
      v = (sel == 0) ? irqReq0 : ((sel == 1) ? irqReq1 : t1Overflow);
    end
    if (v !== 1'b1) begin
      nMismatch++;
      $display("[FAIL] wait for output %0d expected 1 seen %b", sel, v);
      printVerdict();
    end
  endtask : waitFor
  // Run timer 0 from a preload until its request shows, then stop it
  task automatic ovf(logic [7:0] md, logic [7:0] lo, logic [7:0] hi);
    w(ADDR_TIMER_MODE, md);
    w(ADDR_COUNT0_LOW, lo);
    w(ADDR_COUNT0_HIGH, hi);
    w(ADDR_TIMER_CONTROL, 8'h10);
    waitFor(0);
    w(ADDR_TIMER_CONTROL, 8'h20);
  endtask : ovf
  // Mask, then acknowledge the pending overflow
  task automatic ack();
    irqEnable0 = 1'b0;
    repeat (2) @(negedge clk);
    chk1("masked request", 1'b0, irqReq0);
    irqEnable0 = 1'b1;
    irqAck0 = 1'b1;
    @(negedge clk);
    irqAck0 = 1'b0;
    repeat (2) @(negedge clk);
    chk1("request after ack", 1'b0, irqReq0);
    r(ADDR_TIMER_CONTROL);
    chk8("flag after ack", 8'h00, q);
  endtask : ack
  // Main sequence
  initial begin
    rst_b = 1'b0;
    {eventPin0, eventPin1, extIrqIn0, extIrqIn1, extIn0Polarity, extIn1Polarity} = 6'h33;
    {irqEnable0, irqEnable1, irqAck0, irqAck1, extOscClk, arExtTick} = 9'h000;
    repeat (16) @(negedge clk);
    rst_b = 1'b1;
    @(negedge clk);
    foreach (rows[i]) begin
      r(rows[i][23:16]);
      chk8("reset value", 8'h00, q);
      tcd_core_model_i.wrrd(rows[i][23:16], rows[i][15:8], q);
      chk8("readback", rows[i][7:0], q);
    end
    chk8("low clock select", 8'h0F, {4'h0, arLowTick});
    chk8("high clock select", 8'h0C, {4'h0, arHighTick});
    w(ADDR_CLOCK_SELECT, 8'h04);
    arExtTick = 4'h3;
    @(negedge clk);
    chk8("low tick from own clock", 8'h0F, {4'h0, arLowTick});
    chk8("high tick from own clock", 8'h0F, {4'h0, arHighTick});
    arExtTick = 4'h0;
    @(negedge clk);
    chk8("low tick idle", 8'h0C, {4'h0, arLowTick});
    chk8("high tick idle", 8'h0C, {4'h0, arHighTick});
    {extIrqIn0, extIrqIn1} = 2'h0;
    irqEnable0 = 1'b1;
    ovf(8'h01, 8'hFE, 8'hFF);
    r(ADDR_COUNT0_HIGH);
    chk8("16-bit wrap high", 8'h00, q);
    ack();
    ovf(8'h00, 8'h1E, 8'hFF);
    r(ADDR_COUNT0_HIGH);
    chk8("13-bit wrap high", 8'h00, q);
    ack();
    ovf(8'h02, 8'hFE, 8'hF0);
    r(ADDR_COUNT0_HIGH);
    chk8("reload value kept", 8'hF0, q);
    r(ADDR_COUNT0_LOW);
    chk8("reloaded low", 8'hF0, {q[7:4], 4'h0});
    ack();
    // Gate closed holds, opening resumes from the loaded value
    w(ADDR_TIMER_MODE, 8'h09);
    w(ADDR_COUNT0_LOW, 8'h80);
    w(ADDR_TIMER_CONTROL, 8'h10);
    repeat (20) @(negedge clk);
    r(ADDR_COUNT0_LOW);
    chk8("gated off", 8'h80, q);
    extIrqIn0 = 1'b1;
    repeat (20) @(negedge clk);
    w(ADDR_TIMER_CONTROL, 8'h00);
    r(ADDR_COUNT0_LOW);
    chk1("resumed above start", 1'b1, q > 8'h80);
    // Every prescaler choice over a fixed run window
    w(ADDR_TIMER_MODE, 8'h01);
    for (int s = 0; s < 4; s++) begin
      w(ADDR_CLOCK_SELECT, 8'(s));
      w(ADDR_COUNT0_LOW, 8'h00);
      w(ADDR_TIMER_CONTROL, 8'h10);
      // External oscillator with an eight-cycle period for the last choice
      for (int c = 0; c < 480; c++) begin
        if (s == 3) extOscClk = c[2];
        @(negedge clk);
      end
      w(ADDR_TIMER_CONTROL, 8'h00);
      r(ADDR_COUNT0_LOW);
      chk1("prescaled count", 1'b1, (q + 8'h01 - pre[s]) <= 8'h02);
    end
    // Falling pin edges counted by timer 1
    w(ADDR_TIMER_MODE, 8'h50);
    w(ADDR_COUNT1_LOW, 8'h00);
    w(ADDR_TIMER_CONTROL, 8'h40);
    repeat (5) begin
      eventPin1 = 1'b0;
      repeat (4) @(negedge clk);
      eventPin1 = 1'b1;
      repeat (4) @(negedge clk);
    end
    w(ADDR_TIMER_CONTROL, 8'h00);
    r(ADDR_COUNT1_LOW);
    chk8("event count", 8'h05, q);
    // Timer 1 in mode 3 holds
    w(ADDR_CLOCK_SELECT, 8'h08);
    w(ADDR_TIMER_MODE, 8'h30);
    irqEnable1 = 1'b1;
    w(ADDR_TIMER_CONTROL, 8'h40);
    repeat (20) @(negedge clk);
    r(ADDR_COUNT1_LOW);
    chk8("mode 3 hold", 8'h05, q);
    chk1("no timer 1 request", 1'b0, irqReq1);
    // Split mode: timer 1 free on its clock, timer 0 high byte owns flag 1
    w(ADDR_TIMER_CONTROL, 8'h00);
    w(ADDR_CLOCK_SELECT, 8'h0C);
    w(ADDR_COUNT1_LOW, 8'hFC);
    w(ADDR_COUNT1_HIGH, 8'hFF);
    w(ADDR_COUNT0_HIGH, 8'hFD);
    w(ADDR_TIMER_MODE, 8'h53);
    waitFor(2);
    chk1("overflow pulse", 1'b1, t1Overflow);
    @(negedge clk);
    chk1("overflow pulse ends", 1'b0, t1Overflow);
    r(ADDR_TIMER_CONTROL);
    chk8("no flag from timer 1", 8'h00, q);
    w(ADDR_TIMER_CONTROL, 8'h40);
    waitFor(1);
    r(ADDR_TIMER_CONTROL);
    chk8("flag 1 from high byte", 8'hC0, q);
    w(ADDR_TIMER_CONTROL, 8'h00);
    chk1("request after clear", 1'b0, irqReq1);
    // Reset in mid-run clears outputs and registers
    rst_b = 1'b0;
    repeat (2) @(negedge clk);
    rst_b = 1'b1;
    chk8("outputs after reset", 8'h00, {5'h00, irqReq0, irqReq1, t1Overflow});
    @(negedge clk);
    r(ADDR_TIMER_MODE);
    chk8("mode after reset", 8'h00, q);
    r(ADDR_COUNT0_LOW);
    chk8("count after reset", 8'h00, q);
    printVerdict();
  end
endmodule : tb
bind tcd_timer01 tcd_timer01_asserts tcd_timer01_asserts_i (.clk, .rst_b, .sfrAddr,
  .sfrWrData, .sfrWrEn, .sfrRdEn, .sfrRdData, .irqEnable0, .irqEnable1, .arExtTick,
  .arLowTick, .arHighTick, .irqReq0, .irqReq1, .t1Overflow);

/* dv/tcd_core_model.sv */
`timescale 1ns/1ps
module tcd_core_model (
  input wire logic clk,
  input wire logic [7:0] sfrRdData,
  output logic [7:0] sfrAddr,
  output logic [7:0] sfrWrData,
  output logic sfrWrEn,
  output logic sfrRdEn
);
  // Idle bus with strobes low
  initial begin
    sfrAddr = 8'h00;
    sfrWrData = 8'h00;
    sfrWrEn = 1'b0;
    sfrRdEn = 1'b0;
  end
  // Write held over one rising edge; stale data inverted afterwards
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    sfrAddr = a;
    sfrWrData = d;
    sfrWrEn = 1'b1;
    @(negedge clk);
    sfrWrEn = 1'b0;
    sfrWrData = ~d;
    @(negedge clk);
  endtask : wr
  // Read strobe for one edge, data taken a cycle later
  task automatic rd(input logic [7:0] a, output logic [7:0] q);
    sfrAddr = a;
    sfrRdEn = 1'b1;
    @(negedge clk);
    sfrRdEn = 1'b0;
    q = sfrRdData;
    @(negedge clk);
  endtask : rd
  // Write then read of the same place back to back
  task automatic wrrd(input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
    sfrAddr = a;
    sfrWrData = d;
    sfrWrEn = 1'b1;
    @(negedge clk);
    sfrWrEn = 1'b0;
    sfrWrData = ~d;
    sfrRdEn = 1'b1;
    @(negedge clk);
    sfrRdEn = 1'b0;
    q = sfrRdData;
    @(negedge clk);
  endtask : wrrd
endmodule : tcd_core_model

/* dv/tcd_timer01_asserts.sv */
`timescale 1ns/1ps
module tcd_timer01_asserts (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [7:0] sfrAddr,
  input wire logic [7:0] sfrWrData,
  input wire logic sfrWrEn,
  input wire logic sfrRdEn,
  input wire logic [7:0] sfrRdData,
  input wire logic irqEnable0,
  input wire logic irqEnable1,
  input wire logic [3:0] arExtTick,
  input wire logic [3:0] arLowTick,
  input wire logic [3:0] arHighTick,
  input wire logic irqReq0,
  input wire logic irqReq1,
  input wire logic t1Overflow
);
  import tcd_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  // Single register accesses
  sequence rdAt(logic [7:0] a);
    sfrRdEn && !sfrWrEn && sfrAddr == a;
  endsequence
  sequence wrAt(logic [7:0] a);
    sfrWrEn && !sfrRdEn && sfrAddr == a;
  endsequence
  chk_rd_unmapped: assert property (rdAt(8'h00) |=> sfrRdData == 8'h00)
    else $error("unmapped read not zero");
  chk_ext_upper_zero: assert property (rdAt(ADDR_CLOCK_SELECT_EXT) |=> sfrRdData[7:4] == 4'h0)
    else $error("upper select bits not zero");
  chk_sel_write_read: assert property (wrAt(ADDR_CLOCK_SELECT) ##1 rdAt(ADDR_CLOCK_SELECT)
    |=> sfrRdData == $past(sfrWrData, 2)) else $error("select readback wrong");
  chk_rd_data_stands: assert property (!sfrRdEn |=> $stable(sfrRdData))
    else $error("read data moved without read");
  chk_low_tick_ext: assert property ($past(arExtTick) != 4'h0
    |-> (arLowTick & $past(arExtTick)) == $past(arExtTick)) else $error("low tick lost");
  chk_high_tick_ext: assert property ($past(arExtTick) != 4'h0
    |-> (arHighTick & $past(arExtTick)) == $past(arExtTick)) else $error("high tick lost");
  chk_irq0_enable: assert property (irqReq0 |-> $past(irqEnable0))
    else $error("timer 0 request while disabled");
  chk_irq1_enable: assert property (irqReq1 |-> $past(irqEnable1))
    else $error("timer 1 request while disabled");
  chk_reset_quiet: assert property ($rose(rst_b) |-> !irqReq0 && !irqReq1 && !t1Overflow)
    else $error("outputs active after reset");
endmodule : tcd_timer01_asserts

/* verilog/tcd_sync_edge.sv */
`timescale 1ns/1ps
module tcd_sync_edge (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic asyncIn,
  output logic level,
  output logic rise,
  output logic fall
);
  import tcd_pkg::*;

  logic meta_q;
  logic sync_q;
  logic prev_q;

  // Two-flop synchroniser followed by one history flop
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      prev_q <= 1'b0;
    end else begin
      meta_q <= asyncIn;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  // One-cycle edge pulses from the settled samples
  assign level = sync_q;
  assign rise = sync_q & ~prev_q;
  assign fall = ~sync_q & prev_q;

endmodule : tcd_sync_edge

/* verilog/tcd_timer01.sv */
`timescale 1ns/1ps
// Behaviour
// (RL1) Prescaler picks /12, /4, /48, ext/8
// (RL2) Timer 1 select: prescaled or system clock
// (RL3) Timer 0 select: prescaled or system clock
// (RL4) Auto-reload low clock: system or own choice
// (RL5) Auto-reload high clock, split mode only; the code routes it the same way in every mode
// (RL6) Extended select upper nibble reads zero
// (RL7) Count held as low and high bytes
// (RL8) 13-bit: high byte plus low five bits
// (RL9) 13-bit wrap sets flag, may interrupt
// (RL10) Counter counts falling pin edges, else clock
// (RL11) Count only when run and gate allow
// (RL12) Run bit never clears the count
// (RL13) 16-bit mode uses all sixteen bits
// (RL14) 8-bit low byte reloads from high
// (RL15) Split low byte uses timer 0 controls
// (RL16) Split high byte: run1, sets flag1
// (RL17) Split: timer 1 no events, no flag
// (RL18) Split: timer 1 runs unless mode 3
// (RL19) Timer 1 mode 3 holds count
// (RL20) Interrupt only while enable bit set
// (RL21) Mode encoding 13, 16, reload, split
// (RL22) Flag set by hardware, cleared by software/vector
// (RL23) Event source at most quarter clock rate
// (RL24) Synchronise pins, one pulse per event
module tcd_timer01 (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [7:0] sfrAddr,
  input wire logic [7:0] sfrWrData,
  input wire logic sfrWrEn,
  input wire logic sfrRdEn,
  output logic [7:0] sfrRdData,
  input wire logic eventPin0,
  input wire logic eventPin1,
  input wire logic extIrqIn0,
  input wire logic extIrqIn1,
  input wire logic extIn0Polarity,
  input wire logic extIn1Polarity,
  input wire logic irqEnable0,
  input wire logic irqEnable1,
  input wire logic irqAck0,
  input wire logic irqAck1,
  input wire logic extOscClk,
  input wire logic [3:0] arExtTick,
  output logic [3:0] arLowTick,
  output logic [3:0] arHighTick,
  output logic irqReq0,
  output logic irqReq1,
  output logic t1Overflow
);
  import tcd_pkg::*;

  logic [7:0] clkSel_q;
  logic [3:0] clkSelExt_q;
  logic [7:0] timer_control_reg_q;
  logic [7:0] timer_mode_reg_q;
  logic [7:0] count0Low_q;
  logic [7:0] count0High_q;
  logic [7:0] count1Low_q;
  logic [7:0] count1High_q;
  logic [7:0] count0Low_d;
  logic [7:0] count0High_d;
  logic [7:0] count1Low_d;
  logic [7:0] count1High_d;
  logic [5:0] preCnt_q;
  logic [2:0] extCnt_q;
  logic preTick_q;
  logic [7:0] rdData_q;
  logic irqReq0_q;
  logic irqReq1_q;
  logic t1Ovf_q;
  logic [3:0] arLow_q;
  logic [3:0] arHigh_q;

  logic ev0Fall;
  logic ev1Fall;
  logic int0Lvl;
  logic int1Lvl;
  logic oscRise;
  logic [16:0] step0;
  logic [16:0] step1;
  logic t0SysTick;
  logic t1SysTick;
  logic t0Tick;
  logic t1Tick;
  logic t0Enable;
  logic t1Enable;
  logic t0HighTick;
  logic ovf0;
  logic ovf1;
  logic ovf0High;
  logic preTick_d;
  logic split0;

  wire logic [1:0] mode0 = timer_mode_reg_q[TMR_MODE0_LSB +: 2];
  wire logic [1:0] mode1 = timer_mode_reg_q[TMR_MODE1_LSB +: 2];
  wire logic wrHit = sfrWrEn;

  // One increment of a timer in the given mode: {overflow, high, low}
  function automatic logic [16:0] tcd_step(input logic [1:0] mode, input logic [7:0] lo,
                                           input logic [7:0] hi);
    logic [13:0] sum13;
    logic [16:0] sum16;
    logic [8:0] sum8;
    sum13 = {1'b0, hi, lo[4:0]} + 14'h0001;
    sum16 = {1'b0, hi, lo} + 17'h00001;
    sum8 = {1'b0, lo} + 9'h001;
    case (mode)
      MODE_13BIT: tcd_step = {sum13[13], sum13[12:5], lo[7:5], sum13[4:0]}; // RL8 RL9
      MODE_16BIT: tcd_step = sum16; // RL13
      MODE_AUTORELOAD: tcd_step = {sum8[8], hi, sum8[8] ? hi : sum8[7:0]}; // RL14
      MODE_SPLIT: tcd_step = {sum8[8], hi, sum8[7:0]}; // RL15
      default: tcd_step = {1'b0, hi, lo};
    endcase
  endfunction : tcd_step

  // Pin synchronisers and edge detectors
  tcd_sync_edge uEvent0 (.clk(clk), .rst_b(rst_b), .asyncIn(eventPin0), .level(),
    .rise(), .fall(ev0Fall)); // RL24
  tcd_sync_edge uEvent1 (.clk(clk), .rst_b(rst_b), .asyncIn(eventPin1), .level(),
    .rise(), .fall(ev1Fall)); // RL24
  tcd_sync_edge uGate0 (.clk(clk), .rst_b(rst_b), .asyncIn(extIrqIn0), .level(int0Lvl),
    .rise(), .fall()); // RL24
  tcd_sync_edge uGate1 (.clk(clk), .rst_b(rst_b), .asyncIn(extIrqIn1), .level(int1Lvl),
    .rise(), .fall()); // RL24
  tcd_sync_edge uOsc (.clk(clk), .rst_b(rst_b), .asyncIn(extOscClk), .level(),
    .rise(oscRise), .fall()); // RL24

  // Shared prescaler counters
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      preCnt_q <= 6'h00;
      extCnt_q <= 3'h0;
      preTick_q <= 1'b0;
    end else begin
      preCnt_q <= (preCnt_q == PRESCALE_WRAP) ? 6'h00 : preCnt_q + 6'h01;
      if (oscRise) begin
        extCnt_q <= extCnt_q + 3'h1;
      end
      preTick_q <= preTick_d;
    end
  end

  // Prescaled tick selection
  always_comb begin
    case (clkSel_q[CKS_PRESCALE_LSB +: 2])
      PRESCALE_DIV12: preTick_d = (preCnt_q % PRESCALE_DIV12_MOD) == 6'h0B; // RL1
      PRESCALE_DIV4: preTick_d = (preCnt_q % PRESCALE_DIV4_MOD) == 6'h03; // RL1
      PRESCALE_DIV48: preTick_d = preCnt_q == PRESCALE_WRAP; // RL1
      PRESCALE_EXT8: preTick_d = oscRise && (extCnt_q == EXT_DIV8_WRAP); // RL1
      default: preTick_d = 1'b0;
    endcase
  end

  // Tick and enable derivation for both timers
  always_comb begin
    split0 = mode0 == MODE_SPLIT; // RL21
    t0SysTick = clkSel_q[CKS_T0_SYSCLK] | preTick_q; // RL3
    t1SysTick = clkSel_q[CKS_T1_SYSCLK] | preTick_q; // RL2
    t0Tick = timer_mode_reg_q[TMR_CSEL0] ? ev0Fall : t0SysTick; // RL10 RL3
    t0Enable = timer_control_reg_q[TCR_RUN0] &
               (~timer_mode_reg_q[TMR_GATE_ENABLE0] | (int0Lvl == extIn0Polarity)); // RL11 RL15
    t0HighTick = split0 & timer_control_reg_q[TCR_RUN1] & t0SysTick; // RL16
    if (mode1 == MODE_SPLIT) begin
      t1Tick = 1'b0; // RL19 RL18
      t1Enable = 1'b0;
    end else if (split0) begin
      t1Tick = t1SysTick; // RL17
      t1Enable = 1'b1; // RL18
    end else begin
      t1Tick = timer_mode_reg_q[TMR_CSEL1] ? ev1Fall : t1SysTick; // RL10 RL2
      t1Enable = timer_control_reg_q[TCR_RUN1] &
                 (~timer_mode_reg_q[TMR_GATE_ENABLE1] | (int1Lvl == extIn1Polarity)); // RL11
    end
  end

  // Next count values; a byte written by software wins over counting
  always_comb begin
    step0 = tcd_step(mode0, count0Low_q, count0High_q);
    step1 = tcd_step(mode1, count1Low_q, count1High_q);
    count0Low_d = count0Low_q;
    count0High_d = count0High_q;
    count1Low_d = count1Low_q;
    count1High_d = count1High_q;
    ovf0 = 1'b0;
    ovf1 = 1'b0;
    ovf0High = 1'b0;
    if (t0Tick & t0Enable) begin
      count0Low_d = step0[7:0]; // RL12
      count0High_d = step0[15:8];
      ovf0 = step0[16];
    end
    if (t0HighTick) begin
      count0High_d = count0High_q + 8'h01; // RL16
      ovf0High = count0High_q == 8'hFF;
    end
    if (t1Tick & t1Enable) begin
      count1Low_d = step1[7:0];
      count1High_d = step1[15:8];
      ovf1 = step1[16];
    end
    if (wrHit && sfrAddr == ADDR_COUNT0_LOW) count0Low_d = sfrWrData; // RL7
    if (wrHit && sfrAddr == ADDR_COUNT0_HIGH) count0High_d = sfrWrData; // RL7
    if (wrHit && sfrAddr == ADDR_COUNT1_LOW) count1Low_d = sfrWrData; // RL7
    if (wrHit && sfrAddr == ADDR_COUNT1_HIGH) count1High_d = sfrWrData; // RL7
  end

  // Count registers
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      count0Low_q <= RESET_BYTE;
      count0High_q <= RESET_BYTE;
      count1Low_q <= RESET_BYTE;
      count1High_q <= RESET_BYTE;
    end else begin
      count0Low_q <= count0Low_d;
      count0High_q <= count0High_d;
      count1Low_q <= count1Low_d;
      count1High_q <= count1High_d;
    end
  end

  // Mode and clock select registers
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      timer_mode_reg_q <= RESET_BYTE;
      clkSel_q <= RESET_BYTE;
      clkSelExt_q <= RESET_NIBBLE;
    end else if (wrHit) begin
      if (sfrAddr == ADDR_TIMER_MODE) timer_mode_reg_q <= sfrWrData;
      if (sfrAddr == ADDR_CLOCK_SELECT) clkSel_q <= sfrWrData;
      if (sfrAddr == ADDR_CLOCK_SELECT_EXT) clkSelExt_q <= sfrWrData[3:0]; // RL6
    end
  end

  // Control register; hardware set wins over any clear
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      timer_control_reg_q <= RESET_BYTE;
    end else begin
      if (wrHit && sfrAddr == ADDR_TIMER_CONTROL) begin
        timer_control_reg_q <= sfrWrData;
      end
      if (irqAck0) timer_control_reg_q[TCR_FLAG0] <= 1'b0; // RL22
      if (irqAck1) timer_control_reg_q[TCR_FLAG1] <= 1'b0; // RL22
      if (ovf0) timer_control_reg_q[TCR_FLAG0] <= 1'b1; // RL9 RL14 RL15 RL22
      if (ovf0High | (ovf1 & ~split0)) timer_control_reg_q[TCR_FLAG1] <= 1'b1; // RL16 RL17 RL22
    end
  end

  // Interrupt requests and timer 1 overflow for baud consumers
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      irqReq0_q <= 1'b0;
      irqReq1_q <= 1'b0;
      t1Ovf_q <= 1'b0;
    end else begin
      irqReq0_q <= timer_control_reg_q[TCR_FLAG0] & irqEnable0 & ~irqAck0; // RL20 RL9
      irqReq1_q <= timer_control_reg_q[TCR_FLAG1] & irqEnable1 & ~irqAck1; // RL20
      t1Ovf_q <= ovf1; // RL17
    end
  end

  // Clock routing for the four auto-reload timers
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      arLow_q <= RESET_NIBBLE;
      arHigh_q <= RESET_NIBBLE;
    end else begin
      arLow_q[0] <= clkSel_q[CKS_AR2_LOW] | arExtTick[0]; // RL4
      arLow_q[1] <= clkSel_q[CKS_AR3_LOW] | arExtTick[1]; // RL4
      arLow_q[2] <= clkSelExt_q[CKX_AR4_LOW] | arExtTick[2]; // RL4
      arLow_q[3] <= clkSelExt_q[CKX_AR5_LOW] | arExtTick[3]; // RL4
      arHigh_q[0] <= clkSel_q[CKS_AR2_HIGH] | arExtTick[0]; // RL5
      arHigh_q[1] <= clkSel_q[CKS_AR3_HIGH] | arExtTick[1]; // RL5
      arHigh_q[2] <= clkSelExt_q[CKX_AR4_HIGH] | arExtTick[2]; // RL5
      arHigh_q[3] <= clkSelExt_q[CKX_AR5_HIGH] | arExtTick[3]; // RL5
    end
  end

  // Registered read data
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rdData_q <= RESET_BYTE;
    end else if (sfrRdEn) begin
      case (sfrAddr)
        ADDR_TIMER_CONTROL: rdData_q <= timer_control_reg_q;
        ADDR_TIMER_MODE: rdData_q <= timer_mode_reg_q;
        ADDR_COUNT0_LOW: rdData_q <= count0Low_q; // RL7
        ADDR_COUNT0_HIGH: rdData_q <= count0High_q;
        ADDR_COUNT1_LOW: rdData_q <= count1Low_q;
        ADDR_COUNT1_HIGH: rdData_q <= count1High_q;
        ADDR_CLOCK_SELECT: rdData_q <= clkSel_q;
        ADDR_CLOCK_SELECT_EXT: rdData_q <= {CKX_UNUSED_READ, clkSelExt_q}; // RL6
        default: rdData_q <= RESET_BYTE;
      endcase
    end
  end

  // Outputs straight from flops
  assign sfrRdData = rdData_q;
  assign irqReq0 = irqReq0_q;
  assign irqReq1 = irqReq1_q;
  assign t1Overflow = t1Ovf_q;
  assign arLowTick = arLow_q;
  assign arHighTick = arHigh_q;

endmodule : tcd_timer01
